// >>> rtl/sptpc_pkg.sv
package sptpc_pkg;

   // register byte offsets
   localparam logic [4:0] SPTPC_OFS_GLOBAL = 5'h00;
   localparam logic [4:0] SPTPC_OFS_TX_PIN = 5'h04;
   localparam logic [4:0] SPTPC_OFS_IRQ_STATUS = 5'h08;
   localparam logic [4:0] SPTPC_OFS_IRQ_ENABLE = 5'h0c;
   localparam logic [4:0] SPTPC_OFS_IRQ_CLEAR = 5'h10;
   localparam int SPTPC_ADDR_W = 5;

   // global control layout
   localparam int SPTPC_GC_RX_RESET = 27;
   localparam int SPTPC_GC_TX_RESET = 26;
   localparam int SPTPC_GC_RX_FS_MODE = 10;
   localparam int SPTPC_GC_RX_READY = 0;
   localparam int SPTPC_GC_TX_READY = 1;
   localparam int SPTPC_GC_TX_SHIFT_EMPTY = 3;
   localparam int SPTPC_GC_RX_SHIFT_FULL = 4;
   localparam int SPTPC_GC_W = 28;
   localparam logic [31:0] SPTPC_GC_WR_MASK = 32'h0fff_ffe4;
   localparam logic [31:0] SPTPC_GC_RESET = 32'h0000_0000;

   // transmit pin control layout, one nibble per pin
   localparam int SPTPC_PIN_COUNT = 3;
   localparam int SPTPC_PIN_ROLE = 0;
   localparam int SPTPC_PIN_DIR = 1;
   localparam int SPTPC_PIN_OUT = 2;
   localparam int SPTPC_PIN_IN = 3;
   localparam int SPTPC_PIN_STRIDE = 4;
   localparam int SPTPC_PIN_CLOCK = 0;
   localparam int SPTPC_PIN_DATA = 1;
   localparam int SPTPC_PIN_FSYNC = 2;
   localparam logic [31:0] SPTPC_TXP_WR_MASK = 32'h0000_0777;
   localparam logic [31:0] SPTPC_TXP_RESET = 32'h0000_0000;

   // interrupt status layout
   localparam int SPTPC_IRQ_TX_RESET = 0;
   localparam int SPTPC_IRQ_RX_RESET = 1;
   localparam int SPTPC_IRQ_W = 2;
   localparam logic [SPTPC_IRQ_W-1:0] SPTPC_IRQ_RESET = 2'h0;

   // axi responses
   localparam logic [1:0] SPTPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SPTPC_RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {
      SPTPC_SEQ_FRAME_START,
      SPTPC_SEQ_IN_FRAME
   } sptpc_seq_t;

endpackage

// >>> rtl/sptpc_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module sptpc_axil_slave
   import sptpc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // write address and data
   input wire logic [SPTPC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read
   input wire logic [SPTPC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register file side
   output logic wr_en,
   output logic [SPTPC_ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_hit,
   output logic [SPTPC_ADDR_W-1:0] rd_addr,
   output logic rd_en,
   input wire logic [31:0] rd_data,
   input wire logic rd_hit
);

   logic aw_held;
   logic w_held;

   assign wr_en = aw_held && w_held && !s_axi_bvalid;
   assign rd_addr = s_axi_araddr;
   assign rd_en = s_axi_arvalid && s_axi_arready;

   // write address channel
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b0;
         wr_addr <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_en) begin
            aw_held <= 1'b0;
         end else begin
            s_axi_awready <= !aw_held && !s_axi_bvalid;
         end
      end
   end

   // write data channel
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end else begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_en) begin
            w_held <= 1'b0;
         end else begin
            s_axi_wready <= !w_held && !s_axi_bvalid;
         end
      end
   end

   // write response
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SPTPC_RESP_OKAY;
      end else if (wr_en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? SPTPC_RESP_OKAY : SPTPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel, one cycle answer
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= SPTPC_RESP_OKAY;
      end else if (rd_en) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_hit ? SPTPC_RESP_OKAY : SPTPC_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/sptpc_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module sptpc_pin_cell (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // control bits
   input wire logic role,
   input wire logic dir,
   input wire logic out_value,
   // serial core side
   input wire logic core_out,
   input wire logic core_drive,
   // pad
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_n,
   output logic in_level
);

   // serial role ignores dir and out_value
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pin_o <= 1'b0;
         pin_oe_n <= 1'b1;
      end else if (role) begin
         pin_o <= core_out;
         pin_oe_n <= !core_drive;
      end else begin
         pin_o <= out_value;
         pin_oe_n <= !dir;
      end
   end

   // level seen on the pad
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         in_level <= 1'b0;
      end else begin
         in_level <= pin_i;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/sptpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sptpc_top
   import sptpc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // axi4-lite write
   input wire logic [SPTPC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [SPTPC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // serial core status
   input wire logic rx_ready,
   input wire logic tx_ready,
   input wire logic tx_shift_empty,
   input wire logic rx_shift_full,
   // serial core sequencing events
   input wire logic rx_frame_sync_seen,
   input wire logic rx_word_done,
   input wire logic tx_frame_sync_seen,
   input wire logic tx_word_done,
   // serial core controls
   output logic [SPTPC_GC_W-1:0] serial_config,
   output logic receive_side_reset_n,
   output logic transmit_side_reset_n,
   output logic receive_frame_sync_mode,
   output logic rx_in_frame,
   output logic tx_in_frame,
   // serial core pin drive, index 0 clock, 1 data, 2 frame sync
   input wire logic [SPTPC_PIN_COUNT-1:0] core_pin_out,
   input wire logic [SPTPC_PIN_COUNT-1:0] core_pin_drive,
   output logic [SPTPC_PIN_COUNT-1:0] core_pin_in,
   // pads
   input wire logic [SPTPC_PIN_COUNT-1:0] tx_pin_i,
   output logic [SPTPC_PIN_COUNT-1:0] tx_pin_o,
   output logic [SPTPC_PIN_COUNT-1:0] tx_pin_oe_n,
   // interrupt
   output logic irq
);

   logic wr_en;
   logic [SPTPC_ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_hit;
   logic [SPTPC_ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_hit;
   logic [31:0] byte_mask;
   logic [31:0] serial_global_control;
   logic [31:0] tx_pin_control;
   logic [31:0] next_global;
   logic [31:0] next_tx_pin;
   logic [SPTPC_IRQ_W-1:0] irq_status;
   logic [SPTPC_IRQ_W-1:0] irq_enable;
   logic [SPTPC_IRQ_W-1:0] irq_event;
   logic [SPTPC_IRQ_W-1:0] irq_clear;
   logic [SPTPC_PIN_COUNT-1:0] pin_level;
   logic wr_global;
   logic wr_tx_pin;
   sptpc_seq_t rx_seq;
   sptpc_seq_t tx_seq;

   sptpc_axil_slave u_bus (
      .clock(clock),
      .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_hit(wr_hit),
      .rd_addr(rd_addr),
      .rd_en(),
      .rd_data(rd_data),
      .rd_hit(rd_hit)
   );

   // byte enables
   assign byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                       {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wr_global = wr_en && (wr_addr == SPTPC_OFS_GLOBAL);
   assign wr_tx_pin = wr_en && (wr_addr == SPTPC_OFS_TX_PIN);

   // write decode
   always_comb begin
      unique case (wr_addr)
         SPTPC_OFS_GLOBAL,
         SPTPC_OFS_TX_PIN,
         SPTPC_OFS_IRQ_STATUS,
         SPTPC_OFS_IRQ_ENABLE,
         SPTPC_OFS_IRQ_CLEAR: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // merged values, only writable bits change
   always_comb begin
      next_global = (serial_global_control & ~(SPTPC_GC_WR_MASK & byte_mask))
                  | (wr_data & SPTPC_GC_WR_MASK & byte_mask);
      next_tx_pin = (tx_pin_control & ~(SPTPC_TXP_WR_MASK & byte_mask))
                  | (wr_data & SPTPC_TXP_WR_MASK & byte_mask);
   end

   // global control; receive reset touches no register bits
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         serial_global_control <= SPTPC_GC_RESET;
      end else if (wr_global) begin
         serial_global_control <= next_global;
      end
   end

   // transmit pin control
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_pin_control <= SPTPC_TXP_RESET;
      end else if (wr_tx_pin) begin
         tx_pin_control <= next_tx_pin;
      end
   end

   // core controls
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         serial_config <= '0;
         receive_side_reset_n <= 1'b0;
         transmit_side_reset_n <= 1'b0;
         receive_frame_sync_mode <= 1'b0;
      end else begin
         serial_config <= serial_global_control[SPTPC_GC_W-1:0];
         receive_side_reset_n <=
            serial_global_control[SPTPC_GC_RX_RESET];
         transmit_side_reset_n <= serial_global_control[SPTPC_GC_TX_RESET];
         receive_frame_sync_mode <=
            serial_global_control[SPTPC_GC_RX_FS_MODE];
      end
   end

   // receiver sequencing
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_seq <= SPTPC_SEQ_FRAME_START;
      end else if (!serial_global_control[SPTPC_GC_RX_RESET]) begin
         rx_seq <= SPTPC_SEQ_FRAME_START;
      end else begin
         unique case (rx_seq)
            SPTPC_SEQ_FRAME_START: begin
               if (rx_frame_sync_seen) begin
                  rx_seq <= SPTPC_SEQ_IN_FRAME;
               end
            end
            SPTPC_SEQ_IN_FRAME: begin
               if (rx_word_done) begin
                  rx_seq <= SPTPC_SEQ_FRAME_START;
               end
            end
         endcase
      end
   end

   // transmitter sequencing
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_seq <= SPTPC_SEQ_FRAME_START;
      end else if (!serial_global_control[SPTPC_GC_TX_RESET]) begin
         tx_seq <= SPTPC_SEQ_FRAME_START;
      end else begin
         unique case (tx_seq)
            SPTPC_SEQ_FRAME_START: begin
               if (tx_frame_sync_seen) begin
                  tx_seq <= SPTPC_SEQ_IN_FRAME;
               end
            end
            SPTPC_SEQ_IN_FRAME: begin
               if (tx_word_done) begin
                  tx_seq <= SPTPC_SEQ_FRAME_START;
               end
            end
         endcase
      end
   end

   // frame state outputs
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_in_frame <= 1'b0;
         tx_in_frame <= 1'b0;
      end else begin
         rx_in_frame <= (rx_seq == SPTPC_SEQ_IN_FRAME);
         tx_in_frame <= (tx_seq == SPTPC_SEQ_IN_FRAME);
      end
   end

   // reset entry events, from one to zero by a write
   always_comb begin
      irq_event = '0;
      irq_event[SPTPC_IRQ_TX_RESET] = wr_global
         && serial_global_control[SPTPC_GC_TX_RESET]
         && !next_global[SPTPC_GC_TX_RESET];
      irq_event[SPTPC_IRQ_RX_RESET] = wr_global
         && serial_global_control[SPTPC_GC_RX_RESET]
         && !next_global[SPTPC_GC_RX_RESET];
      irq_clear = '0;
      if (wr_en && (wr_addr == SPTPC_OFS_IRQ_CLEAR) && wr_strb[0]) begin
         irq_clear = wr_data[SPTPC_IRQ_W-1:0];
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status <= SPTPC_IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
      end
   end

   // interrupt enable
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irq_enable <= SPTPC_IRQ_RESET;
      end else if (wr_en && (wr_addr == SPTPC_OFS_IRQ_ENABLE)
                   && wr_strb[0]) begin
         irq_enable <= wr_data[SPTPC_IRQ_W-1:0];
      end
   end

   // interrupt line
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   // pin cells: clock, data, frame sync
   genvar gi;
   generate
      for (gi = 0; gi < SPTPC_PIN_COUNT; gi++) begin : g_pin
         sptpc_pin_cell u_cell (
            .clock(clock),
            .sys_rst(sys_rst),
            .role(
               tx_pin_control[gi*SPTPC_PIN_STRIDE+SPTPC_PIN_ROLE]),
            .dir(tx_pin_control[gi*SPTPC_PIN_STRIDE+SPTPC_PIN_DIR]),
            .out_value(
               tx_pin_control[gi*SPTPC_PIN_STRIDE+SPTPC_PIN_OUT]),
            .core_out(core_pin_out[gi]),
            .core_drive(core_pin_drive[gi]),
            .pin_i(tx_pin_i[gi]),
            .pin_o(tx_pin_o[gi]),
            .pin_oe_n(tx_pin_oe_n[gi]),
            .in_level(pin_level[gi])
         );
      end
   endgenerate

   assign core_pin_in = pin_level;

   // read mux
   always_comb begin
      rd_data = '0;
      rd_hit = 1'b1;
      unique case (rd_addr)
         SPTPC_OFS_GLOBAL: begin
            rd_data = serial_global_control & SPTPC_GC_WR_MASK;
            rd_data[SPTPC_GC_RX_READY] = rx_ready;
            rd_data[SPTPC_GC_TX_READY] = tx_ready;
            rd_data[SPTPC_GC_TX_SHIFT_EMPTY] = tx_shift_empty;
            rd_data[SPTPC_GC_RX_SHIFT_FULL] = rx_shift_full;
         end
         SPTPC_OFS_TX_PIN: begin
            rd_data = tx_pin_control & SPTPC_TXP_WR_MASK;
            rd_data[SPTPC_PIN_CLOCK*SPTPC_PIN_STRIDE+SPTPC_PIN_IN] =
               pin_level[SPTPC_PIN_CLOCK];
            rd_data[SPTPC_PIN_DATA*SPTPC_PIN_STRIDE+SPTPC_PIN_IN] =
               pin_level[SPTPC_PIN_DATA];
            rd_data[SPTPC_PIN_FSYNC*SPTPC_PIN_STRIDE+SPTPC_PIN_IN] =
               pin_level[SPTPC_PIN_FSYNC];
         end
         SPTPC_OFS_IRQ_STATUS: rd_data[SPTPC_IRQ_W-1:0] = irq_status;
         SPTPC_OFS_IRQ_ENABLE: rd_data[SPTPC_IRQ_W-1:0] = irq_enable;
         SPTPC_OFS_IRQ_CLEAR: rd_data = '0;
         default: rd_hit = 1'b0;
      endcase
   end

endmodule
`default_nettype wire

// >>> sim/sptpc_props.sv
`timescale 1ns/1ps
`default_nettype none
module sptpc_props
   import sptpc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register bus
   input wire logic [SPTPC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // serial core
   input wire logic receive_side_reset_n,
   input wire logic transmit_side_reset_n,
   input wire logic rx_in_frame,
   input wire logic tx_in_frame,
   input wire logic [SPTPC_PIN_COUNT-1:0] core_pin_out,
   input wire logic [SPTPC_PIN_COUNT-1:0] core_pin_drive,
   input wire logic [SPTPC_PIN_COUNT-1:0] core_pin_in,
   // pads and interrupt
   input wire logic [SPTPC_PIN_COUNT-1:0] tx_pin_i,
   input wire logic [SPTPC_PIN_COUNT-1:0] tx_pin_o,
   input wire logic [SPTPC_PIN_COUNT-1:0] tx_pin_oe_n,
   input wire logic irq
);
   logic [SPTPC_ADDR_W-1:0] aw_a;
   logic [31:0] w_d;
   logic [3:0] w_s;
   logic [11:0] pc;
   logic bv_q;

   // shadow of pin control, taken when the write response appears
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         aw_a <= '0;
         w_d <= 32'h0;
         w_s <= 4'h0;
         pc <= 12'h000;
         bv_q <= 1'b0;
      end else begin
         bv_q <= s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) aw_a <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) w_d <= s_axi_wdata;
         if (s_axi_wvalid && s_axi_wready) w_s <= s_axi_wstrb;
         if (s_axi_bvalid && !bv_q && aw_a == SPTPC_OFS_TX_PIN) begin
            if (w_s[0]) pc[7:0] <= w_d[7:0];
            if (w_s[1]) pc[11:8] <= w_d[11:8];
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   property p_rx_hold;
      !receive_side_reset_n [*3] |=> !rx_in_frame;
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("receiver left frame start in reset");
   property p_tx_hold;
      !transmit_side_reset_n [*3] |=> !tx_in_frame;
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("transmitter left frame start in reset");
   property p_rsvd;
      s_axi_rvalid |-> s_axi_rdata[31:28] == 4'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved read bits not zero");
   property p_rst_pins;
      $fell(sys_rst) |-> tx_pin_oe_n == 3'h7 && !receive_side_reset_n;
   endproperty
   a_rst_pins: assert property (p_rst_pins)
      else $error("pins or resets wrong after reset");
   property p_sample;
      !sys_rst |=> core_pin_in == $past(tx_pin_i);
   endproperty
   a_sample: assert property (p_sample)
      else $error("pad level not sampled");

   for (genvar k = 0; k < SPTPC_PIN_COUNT; k++) begin : g_pin
      property p_gp_out;
         !pc[4*k] && pc[4*k+1] |->
            !tx_pin_oe_n[k] && tx_pin_o[k] == pc[4*k+2];
      endproperty
      a_gp_out: assert property (p_gp_out)
         else $error("output pin not driven from value bit");
      property p_gp_in;
         !pc[4*k] && !pc[4*k+1] |-> tx_pin_oe_n[k];
      endproperty
      a_gp_in: assert property (p_gp_in)
         else $error("input pin driven");
      property p_serial;
         pc[4*k] |-> tx_pin_o[k] == $past(core_pin_out[k]) &&
            tx_pin_oe_n[k] == !$past(core_pin_drive[k]);
      endproperty
      a_serial: assert property (p_serial)
         else $error("serial pin not following core");
   end

   c_rx_rst: cover property ($fell(receive_side_reset_n));
   c_irq: cover property ($rose(irq));
   c_serial: cover property (pc[0] && core_pin_drive[0]);
endmodule

bind sptpc_top sptpc_props u_props (.clock, .sys_rst, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rvalid,
   .s_axi_rdata, .receive_side_reset_n, .transmit_side_reset_n,
   .rx_in_frame, .tx_in_frame, .core_pin_out, .core_pin_drive,
   .core_pin_in, .tx_pin_i, .tx_pin_o, .tx_pin_oe_n, .irq);
`default_nettype wire

// >>> sim/sptpc_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sptpc_pin_partner (
   // pad side of the design
   input wire logic [2:0] pin_o,
   input wire logic [2:0] pin_oe_n,
   // level the far device puts on pins the design leaves alone
   input wire logic [2:0] ext_lvl,
   output logic [2:0] pin_i
);
   assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext_lvl);
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sptpc_pkg::*;
   typedef struct packed {
      logic [31:0] w;
      logic [2:0] e, co, cd;
      logic [11:0] rx;
      logic [2:0] oen, po;
   } sptpc_row_t;
   sptpc_row_t rows [5] = '{
      '{32'h0000_0000, 3'h5, 3'h0, 3'h0, 12'h808, 3'h7, 3'h0},
      '{32'h0000_0666, 3'h0, 3'h0, 3'h0, 12'heee, 3'h0, 3'h7},
      '{32'hffff_f0a2, 3'h7, 3'h0, 3'h0, 12'h822, 3'h4, 3'h0},
      '{32'h0000_0111, 3'h0, 3'h3, 3'h6, 12'h191, 3'h1, 3'h2},
      '{32'h0000_0d5d, 3'h2, 3'h5, 3'h7, 12'hd5d, 3'h0, 3'h5}};
   logic clock = 1'b0, sys_rst = 1'b1;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq, rx_in_frame, tx_in_frame;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic rx_ready = 1'b0, tx_ready = 1'b0;
   logic tx_shift_empty = 1'b0, rx_shift_full = 1'b0;
   logic rx_frame_sync_seen = 1'b0, tx_frame_sync_seen = 1'b0;
   logic rx_word_done = 1'b0, tx_word_done = 1'b0;
   logic [SPTPC_GC_W-1:0] serial_config;
   logic receive_side_reset_n, transmit_side_reset_n;
   logic receive_frame_sync_mode;
   logic [2:0] core_pin_out = 3'h0, core_pin_drive = 3'h0, ext = 3'h0;
   logic [2:0] core_pin_in, tx_pin_i, tx_pin_o, tx_pin_oe_n;
   int fail_count = 0, checks = 0;

   always #25 clock = ~clock;

   sptpc_top u_dut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_ready, .tx_ready,
      .tx_shift_empty, .rx_shift_full, .rx_frame_sync_seen, .rx_word_done,
      .tx_frame_sync_seen, .tx_word_done, .serial_config,
      .receive_side_reset_n, .transmit_side_reset_n,
      .receive_frame_sync_mode, .rx_in_frame, .tx_in_frame, .core_pin_out,
      .core_pin_drive, .core_pin_in, .tx_pin_i, .tx_pin_o, .tx_pin_oe_n,
      .irq);
   sptpc_pin_partner u_far (.pin_o(tx_pin_o), .pin_oe_n(tx_pin_oe_n),
      .ext_lvl(ext), .pin_i(tx_pin_i));

   task automatic chk(input logic [31:0] seen, exp, input string m);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask

   task automatic rd(input logic [4:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd_v = s_axi_rdata;
      rs = s_axi_rresp;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      conclude();
   end

   initial begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      rd(SPTPC_OFS_TX_PIN);
      chk(rd_v, 32'h0, "pin control after reset");
      chk({29'h0, tx_pin_oe_n}, 32'h7, "pins idle after reset");
      $display("reset test done");
      foreach (rows[i]) begin
         @(posedge clock);
         ext <= rows[i].e;
         core_pin_out <= rows[i].co;
         core_pin_drive <= rows[i].cd;
         wr(SPTPC_OFS_TX_PIN, rows[i].w);
         repeat (2) @(posedge clock);
         rd(SPTPC_OFS_TX_PIN);
         chk(rd_v, {20'h0, rows[i].rx}, "pin readback");
         chk({29'h0, tx_pin_oe_n}, {29'h0, rows[i].oen}, "pin enable");
         chk({29'h0, tx_pin_o & ~tx_pin_oe_n}, {29'h0, rows[i].po},
            "pin out");
         $display("row %0d done", i);
      end
      rx_ready <= 1'b1;
      rx_shift_full <= 1'b1;
      wr(SPTPC_OFS_GLOBAL, 32'hffff_ffff);
      rd(SPTPC_OFS_GLOBAL);
      chk(rd_v, 32'h0fff_fff5, "global readback");
      rx_frame_sync_seen <= 1'b1;
      tx_frame_sync_seen <= 1'b1;
      @(posedge clock);
      rx_frame_sync_seen <= 1'b0;
      tx_frame_sync_seen <= 1'b0;
      repeat (3) @(posedge clock);
      chk({30'h0, rx_in_frame, tx_in_frame}, 32'h3, "in frame");
      wr(SPTPC_OFS_IRQ_ENABLE, 32'h3);
      // receive reset in the same write as the receive mode bits
      wr(SPTPC_OFS_GLOBAL, 32'h07ff_ffe4);
      repeat (3) @(posedge clock);
      chk({29'h0, receive_side_reset_n, rx_in_frame, tx_in_frame}, 32'h1,
         "receiver reset");
      rd(SPTPC_OFS_GLOBAL);
      chk(rd_v, 32'h07ff_fff5, "config kept");
      chk({4'h0, serial_config}, 32'h07ff_ffe4, "core config");
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(SPTPC_OFS_IRQ_CLEAR, 32'h3);
      wr(SPTPC_OFS_GLOBAL, 32'h0fff_fbe4);
      repeat (2) @(posedge clock);
      chk({30'h0, receive_frame_sync_mode, receive_side_reset_n}, 32'h1,
         "mode change");
      wr(SPTPC_OFS_GLOBAL, 32'h0bff_fbe4);
      rd(SPTPC_OFS_IRQ_STATUS);
      chk(rd_v, 32'h1, "transmit reset event");
      chk({29'h0, transmit_side_reset_n, tx_in_frame, irq}, 32'h1,
         "transmit reset irq");
      wr(SPTPC_OFS_IRQ_CLEAR, 32'h1);
      wr(SPTPC_OFS_IRQ_ENABLE, 32'h0);
      wr(SPTPC_OFS_GLOBAL, 32'h0fff_fbe4);
      wr(SPTPC_OFS_GLOBAL, 32'h0bff_fbe4);
      rd(SPTPC_OFS_IRQ_STATUS);
      chk({rd_v[30:0], irq}, 32'h2, "masked event");
      $display("global test done");
      wr(5'h14, 32'hffff_ffff);
      chk({30'h0, rs}, {30'h0, SPTPC_RESP_SLVERR}, "unmapped write");
      rd(5'h14);
      chk({rd_v[29:0], rs}, {30'h0, SPTPC_RESP_SLVERR}, "unmapped read");
      wr(SPTPC_OFS_TX_PIN, 32'h0000_0666);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      s_axi_wstrb <= 4'h1;
      wr(SPTPC_OFS_TX_PIN, 32'h0000_0777);
      repeat (2) @(posedge clock);
      rd(SPTPC_OFS_TX_PIN);
      chk(rd_v, 32'h0000_007f, "lane write after reset");
      $display("bus test done");
      conclude();
   end
endmodule
`default_nettype wire
